//--- rtl/tw_timer8_regs.svh
// Purpose: Register offsets, field positions, reset values and counts of the 8-bit wave timer
// Assumes: One 32-bit APB word per register, byte addresses
// Notes:   Definitions only
`ifndef TW_TIMER8_REGS_SVH
`define TW_TIMER8_REGS_SVH

// Register byte offsets
`define TW_CTRL_OFS       8'h00
`define TW_COUNT_OFS      8'h04
`define TW_COMPARE_OFS    8'h08
`define TW_FLAGS_OFS      8'h0C
`define TW_PORT_OFS       8'h10

// Control register fields
`define TW_CTRL_MODE_LSB  0
`define TW_CTRL_ACT_LSB   4
`define TW_CTRL_FORCE_BIT 7

// Flag register fields
`define TW_FLAG_OVF_BIT   0
`define TW_FLAG_MATCH_BIT 1

// Port register fields
`define TW_PORT_VAL_BIT   0
`define TW_PORT_DIR_BIT   1

// Counter values and reset values
`define TW_CNT_MAX        8'hFF
`define TW_CNT_BOTTOM     8'h00
`define TW_RST_BYTE       8'h00
`define TW_RST_WORD       32'h0000_0000

`endif

//--- rtl/tw_pkg.sv
// Purpose: Types shared by the 8-bit wave timer and its bench
// Assumes: Constants live in tw_timer8_regs.svh
// Notes:   Enum order gives the field encodings 0..3
package tw_pkg;

  typedef logic [31:0] tw_word_t;
  typedef logic [7:0]  tw_byte_t;

  // Counting sequence chosen by wave_mode_sel
  typedef enum logic [1:0] {
    TW_MODE_NORMAL,
    TW_MODE_PHASE,
    TW_MODE_CTC,
    TW_MODE_FAST
  } tw_mode_t;

  // Pin action chosen by output_action_sel
  typedef enum logic [1:0] {
    TW_ACT_OFF,
    TW_ACT_TOGGLE,
    TW_ACT_CLEAR,
    TW_ACT_SET
  } tw_act_t;

endpackage

//--- rtl/tw_timer8.sv
// Purpose: 8-bit timer with one compare channel, wave modes and pin override, APB slave
// Assumes: i_timer_tick is a one-cycle enable from a prescaler on i_sys_clk
// Notes:   Phase correct mode is not built; in that mode the counter holds still
//
// Function
// (RL1) Nonzero action routes compare_output to pin
// (RL2) Direction bit alone enables pin driver
// (RL3) Override depends only on action select
// (RL4) Action zero leaves compare_output unchanged
// (RL5) New action applies at next match; force
// (RL6) Only wave mode selects counting sequence
// (RL7) Mode 0 increments and wraps FF to 00
// (RL8) Mode 0 overflow set as count hits zero
// (RL9) Mode 2 clears counter after compare match
// (RL10) Mode 2 compare writes unbuffered, may wrap
// (RL11) Mode 2 match flag raised each period
// (RL12) Mode 2 action 1 toggles on match
// (RL13) Mode 2 overflow set on MAX wrap
// (RL14) Mode 3 counts 0 to MAX, 256 ticks
// (RL15) Mode 3 action 2 normal, 3 inverted
// (RL16) Fast PWM: match clears, bottom sets
// (RL17) Mode 3 overflow set at maximum
// (RL18) Compare zero spikes, MAX gives constant level
// (RL19) Mode 3 action 1 toggles, buffer kept
// (RL20) PWM compare writes buffered until top
// (RL21) Match flag set tick after equality
// (RL22) Count write blocks next tick match
// (RL23) Everything resets to zero, mode 0
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ns
`include "tw_timer8_regs.svh"

module tw_timer8 #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_sys_rst,
  // Timer tick enable
  input  wire logic              i_timer_tick,
  // Flag clear by interrupt service (bit 0 overflow, bit 1 match)
  input  wire logic [1:0]        i_flag_ack,
  // APB slave
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire tw_pkg::tw_word_t  i_pwdata,
  output logic                   o_pready,
  output tw_pkg::tw_word_t       o_prdata,
  output logic                   o_pslverr,
  // Pin stage
  output logic                   o_pin_out,
  output logic                   o_pin_oe,
  // Status
  output logic                   o_overflow_flag,
  output logic                   o_match_flag
);
  import tw_pkg::*;

  // State
  tw_mode_t    mode_q;
  tw_act_t     act_q;
  tw_byte_t    count_q;
  tw_byte_t    cmp_buf_q;
  tw_byte_t    cmp_act_q;
  logic        ovf_q;
  logic        match_q;
  logic        oc_q;
  logic        block_q;
  logic        port_val_q;
  logic        dir_q;
  logic        pready_q;
  tw_word_t    prdata_q;
  logic        pslverr_q;
  logic        pin_out_q;
  logic        pin_oe_q;

  // Bus decode
  wire         setup_ph   = i_psel & ~i_penable;
  wire         access_ph  = i_psel & i_penable & pready_q;
  wire         bus_wr     = access_ph & i_pwrite;
  wire         hit_ctrl   = (i_paddr == ADDR_W'(`TW_CTRL_OFS));
  wire         hit_count  = (i_paddr == ADDR_W'(`TW_COUNT_OFS));
  wire         hit_cmp    = (i_paddr == ADDR_W'(`TW_COMPARE_OFS));
  wire         hit_flags  = (i_paddr == ADDR_W'(`TW_FLAGS_OFS));
  wire         hit_port   = (i_paddr == ADDR_W'(`TW_PORT_OFS));
  wire         mapped     = hit_ctrl | hit_count | hit_cmp | hit_flags | hit_port;
  wire         ctrl_wr    = bus_wr & hit_ctrl;
  wire         cnt_wr     = bus_wr & hit_count;
  wire         cmp_wr     = bus_wr & hit_cmp;
  wire         flags_wr   = bus_wr & hit_flags;
  wire         port_wr    = bus_wr & hit_port;

  // Written control fields
  wire tw_mode_t new_mode = tw_mode_t'(i_pwdata[`TW_CTRL_MODE_LSB +: 2]);
  wire tw_act_t  new_act  = tw_act_t'(i_pwdata[`TW_CTRL_ACT_LSB +: 2]);

  // Counter events
  wire         is_pwm     = (mode_q == TW_MODE_FAST) | (mode_q == TW_MODE_PHASE);
  wire         at_max     = (count_q == `TW_CNT_MAX);
  wire         cmp_eq     = (count_q == cmp_act_q);
  wire         running    = i_timer_tick & (mode_q != TW_MODE_PHASE);
  wire         match_ev   = running & cmp_eq & ~block_q;              // see RL22
  wire         wrap_ev    = running & at_max & ~cnt_wr;
  wire         ctc_clr    = (mode_q == TW_MODE_CTC) & match_ev;       // see RL9
  wire         force_ev   = ctrl_wr & i_pwdata[`TW_CTRL_FORCE_BIT] & ~new_mode[0];

  // Next count: bus write first, then clear, then increment
  tw_byte_t    count_d;
  always_comb begin
    count_d = count_q;
    if (cnt_wr) begin                                                 // see RL22
      count_d = i_pwdata[7:0];
    end else if (ctc_clr) begin                                       // see RL9
      count_d = `TW_CNT_BOTTOM;
    end else if (running) begin                                       // see RL6, RL7, RL14
      count_d = count_q + 8'h01;
    end
  end

  // Non-PWM pin action, shared by the force strobe and a real match
  function automatic logic act_apply(input tw_act_t act, input logic oc);
    case (act)
      TW_ACT_TOGGLE: act_apply = ~oc;                                 // see RL12
      TW_ACT_CLEAR:  act_apply = 1'b0;
      TW_ACT_SET:    act_apply = 1'b1;
      default:       act_apply = oc;                                  // see RL4
    endcase
  endfunction

  // Wave generator next state
  logic        oc_d;
  always_comb begin
    oc_d = oc_q;
    if (force_ev) begin                                               // see RL5
      oc_d = act_apply(new_act, oc_q);
    end else if (mode_q == TW_MODE_FAST) begin
      case (act_q)
        TW_ACT_TOGGLE: oc_d = match_ev ? ~oc_q : oc_q;                // see RL19
        TW_ACT_CLEAR: begin                                           // see RL15, RL16
          if (wrap_ev) begin
            oc_d = 1'b1;                                              // see RL18
          end else if (match_ev) begin
            oc_d = 1'b0;
          end
        end
        TW_ACT_SET: begin                                             // see RL15, RL16
          if (wrap_ev) begin
            oc_d = 1'b0;                                              // see RL18
          end else if (match_ev) begin
            oc_d = 1'b1;
          end
        end
        default:       oc_d = oc_q;                                   // see RL4
      endcase
    end else if (match_ev) begin                                      // see RL5
      oc_d = act_apply(act_q, oc_q);
    end
  end

  // Register read mux
  tw_word_t    rdata_d;
  always_comb begin
    rdata_d = `TW_RST_WORD;
    if (hit_ctrl) begin
      rdata_d[`TW_CTRL_MODE_LSB +: 2] = mode_q;
      rdata_d[`TW_CTRL_ACT_LSB +: 2]  = act_q;
    end else if (hit_count) begin
      rdata_d[7:0] = count_q;
    end else if (hit_cmp) begin
      rdata_d[7:0] = cmp_buf_q;
    end else if (hit_flags) begin
      rdata_d[`TW_FLAG_OVF_BIT]   = ovf_q;
      rdata_d[`TW_FLAG_MATCH_BIT] = match_q;
    end else if (hit_port) begin
      rdata_d[`TW_PORT_VAL_BIT] = port_val_q;
      rdata_d[`TW_PORT_DIR_BIT] = dir_q;
    end
  end

  // Flags: hardware set wins over a software or service clear
  wire ovf_clr   = (flags_wr & i_pwdata[`TW_FLAG_OVF_BIT]) | i_flag_ack[0];
  wire match_clr = (flags_wr & i_pwdata[`TW_FLAG_MATCH_BIT]) | i_flag_ack[1];
  wire ovf_d     = wrap_ev | (ovf_q & ~ovf_clr);                      // see RL8, RL13, RL17
  wire match_d   = match_ev | (match_q & ~match_clr);                 // see RL11, RL21

  // Compare registers: direct in non-PWM, double buffered in PWM
  wire tw_byte_t cmp_act_d = (cmp_wr & ~is_pwm) ? i_pwdata[7:0] :     // see RL10
                             (is_pwm & wrap_ev) ? cmp_buf_q :         // see RL20
                             cmp_act_q;

  // Pin stage
  wire         override = (act_q != TW_ACT_OFF);                      // see RL1, RL3
  wire         pin_d    = override ? oc_q : port_val_q;

  // Control and bus registers
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin                                              // see RL23
      mode_q     <= TW_MODE_NORMAL;
      act_q      <= TW_ACT_OFF;
      port_val_q <= 1'b0;
      dir_q      <= 1'b0;
      cmp_buf_q  <= `TW_RST_BYTE;
      pready_q   <= 1'b0;
      prdata_q   <= `TW_RST_WORD;
      pslverr_q  <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        mode_q <= new_mode;
        act_q  <= new_act;
      end
      if (port_wr) begin
        port_val_q <= i_pwdata[`TW_PORT_VAL_BIT];
        dir_q      <= i_pwdata[`TW_PORT_DIR_BIT];
      end
      if (cmp_wr) begin
        cmp_buf_q <= i_pwdata[7:0];
      end
      // Answer is set up during the setup cycle so pready leaves a flop
      pready_q  <= setup_ph;
      prdata_q  <= (setup_ph & ~i_pwrite) ? rdata_d : `TW_RST_WORD;
      pslverr_q <= setup_ph & ~mapped;
    end
  end

  // Counter, wave and flag registers
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin                                              // see RL23
      count_q   <= `TW_RST_BYTE;
      cmp_act_q <= `TW_RST_BYTE;
      ovf_q     <= 1'b0;
      match_q   <= 1'b0;
      oc_q      <= 1'b0;
      block_q   <= 1'b0;
      pin_out_q <= 1'b0;
      pin_oe_q  <= 1'b0;
    end else begin
      count_q   <= count_d;
      cmp_act_q <= cmp_act_d;
      ovf_q     <= ovf_d;
      match_q   <= match_d;
      oc_q      <= oc_d;
      // Block lasts until the next tick, even with the timer stopped
      block_q   <= cnt_wr | (block_q & ~i_timer_tick);                // see RL22
      pin_out_q <= pin_d;
      pin_oe_q  <= dir_q;                                             // see RL2
    end
  end

  assign o_pready        = pready_q;
  assign o_prdata        = prdata_q;
  assign o_pslverr       = pslverr_q;
  assign o_pin_out       = pin_out_q;
  assign o_pin_oe        = pin_oe_q;
  assign o_overflow_flag = ovf_q;
  assign o_match_flag    = match_q;

  // Checks

  property p_ovf_at_wrap;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (running && at_max && !cnt_wr) |=> (ovf_q && count_q == `TW_CNT_BOTTOM);
  endproperty
  a_ovf_at_wrap: assert property (p_ovf_at_wrap) else $error("overflow flag missed at wrap"); // see RL8

  property p_normal_inc;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (mode_q == TW_MODE_NORMAL && i_timer_tick && !cnt_wr) |=> (count_q == $past(count_q) + 8'h01);
  endproperty
  a_normal_inc: assert property (p_normal_inc) else $error("normal mode did not increment"); // see RL7

  property p_ctc_clear;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (ctc_clr && !cnt_wr) |=> (count_q == `TW_CNT_BOTTOM && match_q);
  endproperty
  a_ctc_clear: assert property (p_ctc_clear) else $error("clear on match failed"); // see RL9

  property p_write_blocks;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    cnt_wr |=> (!match_ev && block_q);
  endproperty
  a_write_blocks: assert property (p_write_blocks) else $error("match not blocked after count write"); // see RL22

  property p_match_flag;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    match_ev |=> match_q;
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("match flag not set"); // see RL21

  property p_off_holds;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (act_q == TW_ACT_OFF && !force_ev) |=> $stable(oc_q);
  endproperty
  a_off_holds: assert property (p_off_holds) else $error("compare output moved with action off"); // see RL4

  property p_pin_route;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (act_q != TW_ACT_OFF) |=> (o_pin_out == $past(oc_q));
  endproperty
  a_pin_route: assert property (p_pin_route) else $error("pin not driven from compare output"); // see RL1

  property p_pin_dir;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    1'b1 |=> (o_pin_oe == $past(dir_q));
  endproperty
  a_pin_dir: assert property (p_pin_dir) else $error("pin enable not from direction bit"); // see RL2

  property p_fast_bottom_set;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (mode_q == TW_MODE_FAST && act_q == TW_ACT_CLEAR && wrap_ev && !ctrl_wr) |=> oc_q;
  endproperty
  a_fast_bottom_set: assert property (p_fast_bottom_set) else $error("fast PWM not set at bottom"); // see RL16

  property p_pwm_buffer;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (mode_q == TW_MODE_FAST && !wrap_ev) |=> $stable(cmp_act_q);
  endproperty
  a_pwm_buffer: assert property (p_pwm_buffer) else $error("PWM compare changed off top"); // see RL20

  property p_ctc_toggle;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (mode_q == TW_MODE_CTC && act_q == TW_ACT_TOGGLE && match_ev && !ctrl_wr) |=> (oc_q != $past(oc_q));
  endproperty
  a_ctc_toggle: assert property (p_ctc_toggle) else $error("toggle on match failed"); // see RL12

  property p_force_apply;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (force_ev && new_act == TW_ACT_CLEAR) |=> !oc_q;
  endproperty
  a_force_apply: assert property (p_force_apply) else $error("force strobe did not clear compare output"); // see RL5

  property p_fast_inv_bottom;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (mode_q == TW_MODE_FAST && act_q == TW_ACT_SET && wrap_ev && !ctrl_wr) |=> !oc_q;
  endproperty
  a_fast_inv_bottom: assert property (p_fast_inv_bottom) else $error("inverted PWM not cleared at bottom"); // see RL16

  property p_fast_match_clear;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (mode_q == TW_MODE_FAST && act_q == TW_ACT_CLEAR && match_ev && !wrap_ev && !ctrl_wr) |=> !oc_q;
  endproperty
  a_fast_match_clear: assert property (p_fast_match_clear) else $error("fast PWM not cleared on match"); // see RL16

  property p_pwm_copy;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (mode_q == TW_MODE_FAST && wrap_ev) |=> (cmp_act_q == $past(cmp_buf_q));
  endproperty
  a_pwm_copy: assert property (p_pwm_copy) else $error("PWM compare buffer not copied at wrap"); // see RL20

  property p_direct_cmp;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (cmp_wr && !is_pwm) |=> (cmp_act_q == cmp_buf_q);
  endproperty
  a_direct_cmp: assert property (p_direct_cmp) else $error("non-PWM compare write not direct"); // see RL10

  property p_fast_wrap;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (mode_q == TW_MODE_FAST && running && at_max && !cnt_wr) |=> (count_q == `TW_CNT_BOTTOM);
  endproperty
  a_fast_wrap: assert property (p_fast_wrap) else $error("fast PWM counter did not restart"); // see RL14

  property p_ovf_sticky;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (ovf_q && !ovf_clr) |=> ovf_q;
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag cleared by counting"); // see RL8

  property p_match_clear;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (match_clr && !match_ev) |=> !match_q;
  endproperty
  a_match_clear: assert property (p_match_clear) else $error("match flag not cleared"); // see RL21

  property p_pin_port;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (act_q == TW_ACT_OFF) |=> (o_pin_out == $past(port_val_q));
  endproperty
  a_pin_port: assert property (p_pin_port) else $error("pin not driven from port value"); // see RL1

endmodule // tw_timer8

//--- dv/tw_pin_model.sv
// Purpose: Pad shared between the timer pin stage and the port logic
// Assumes: No pull resistor on the pad
// Notes:   An undriven pad changes every cycle so a stale level is never mistaken for a drive
`timescale 1ns/1ns

module tw_pin_model (
  // Clock
  input  wire logic i_sys_clk,
  // Pin stage of the timer
  input  wire logic i_pin_out,
  input  wire logic i_pin_oe,
  // Pad level
  output logic      o_pad
);
  logic last_q = 1'b0;

  always @(posedge i_sys_clk) begin
    last_q <= o_pad;
  end

  // Only the direction bit lets the timer reach the pad
  assign o_pad = i_pin_oe ? i_pin_out : ~last_q;
endmodule // tw_pin_model

//--- dv/tw_timer8_tb.sv
// Purpose: Self-checking bench for the 8-bit wave timer
// Assumes: Zero-wait APB slave, tick pulses made by the bench
// Notes:   Ticks are single pulses so every counter step is known, except the steady tick of the clear-on-match check
`timescale 1ns/1ns
`include "tw_timer8_regs.svh"

module tw_timer8_tb;
  import tw_pkg::*;
  typedef struct {logic [7:0] a; tw_word_t w; tw_word_t r; logic e;} tw_row_t;

  logic       clk = 0, rst = 1, tick = 0, psel = 0, pen = 0, pwr = 0, se;
  logic [1:0] ack = 0;
  logic [7:0] adr = 0;
  tw_word_t   wd = 0, rdat, rd;
  logic       rdy, serr, pout, poe, ovf, mat, pad, pv;
  int         error_cnt = 0, n_tests = 0;
  tw_row_t    rows [6] = '{
    '{`TW_CTRL_OFS, 32'h0000_00B2, 32'h0000_0032, 1'b0},
    '{`TW_COUNT_OFS, 32'h0000_01A5, 32'h0000_00A5, 1'b0},
    '{`TW_COMPARE_OFS, 32'h0000_FF3C, 32'h0000_003C, 1'b0},
    '{`TW_PORT_OFS, 32'hFFFF_FFFD, 32'h0000_0001, 1'b0},
    '{`TW_FLAGS_OFS, 32'h0000_0003, 32'h0000_0000, 1'b0},
    '{8'h14, 32'h0000_00FF, 32'h0000_0000, 1'b1}};

  always #5 clk = ~clk;

  tw_timer8 DUT (
    .i_sys_clk(clk), .i_sys_rst(rst), .i_timer_tick(tick), .i_flag_ack(ack),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(adr), .i_pwdata(wd),
    .o_pready(rdy), .o_prdata(rdat), .o_pslverr(serr), .o_pin_out(pout), .o_pin_oe(poe),
    .o_overflow_flag(ovf), .o_match_flag(mat));

  tw_pin_model PIN (.i_sys_clk(clk), .i_pin_out(pout), .i_pin_oe(poe), .o_pad(pad));

  task automatic chk(input string n, input tw_word_t got, input tw_word_t exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input tw_word_t d);
    int k;
    @(posedge clk);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    pen <= 1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (rdy !== 1'b1 && k < 20);
    rd = rdat;
    se = serr;
    if (k >= 20) chk("pready", 0, 1);
    psel <= 0;
    pen <= 0;
  endtask

  task automatic wr(input logic [7:0] a, input tw_word_t d);
    apb(1, a, d);
  endtask

  task automatic rc(input string n, input logic [7:0] a, input tw_word_t e);
    apb(0, a, 0);
    chk(n, rd, e);
  endtask

  task automatic st;
    repeat (2) @(negedge clk);
  endtask

  task automatic tk(input int n);
    repeat (n) begin
      @(posedge clk);
      tick <= 1;
      @(posedge clk);
      tick <= 0;
    end
    st();
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    chk("outs", {pout, poe, ovf, mat}, 0);
    for (int i = 0; i < 5; i++) rc("rst", 8'(4 * i), 0);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      chk("werr", se, rows[i].e);
      rc("reg", rows[i].a, rows[i].r);
      chk("rerr", se, rows[i].e);
    end
    // Normal mode wrap and sticky overflow
    wr(`TW_CTRL_OFS, 0);
    wr(`TW_COMPARE_OFS, 32'h10);
    wr(`TW_COUNT_OFS, 32'hFD);
    wr(`TW_FLAGS_OFS, 3);
    tk(2);
    chk("ovf", ovf, 0);
    rc("cnt", `TW_COUNT_OFS, 32'hFF);
    tk(1);
    chk("ovf", ovf, 1);
    rc("cnt", `TW_COUNT_OFS, 0);
    tk(2);
    chk("ovf", ovf, 1);
    wr(`TW_FLAGS_OFS, 1);
    st();
    chk("ovf", ovf, 0);
    // A count write hides the match of the following tick
    wr(`TW_COMPARE_OFS, 32'h40);
    wr(`TW_COUNT_OFS, 32'h40);
    wr(`TW_FLAGS_OFS, 3);
    tk(1);
    chk("mat", mat, 0);
    wr(`TW_COUNT_OFS, 32'h3F);
    tk(2);
    chk("mat", mat, 1);
    @(posedge clk);
    ack <= 2'b10;
    @(posedge clk);
    ack <= 0;
    st();
    chk("mat", mat, 0);
    // Port value, force strobe and override
    wr(`TW_PORT_OFS, 3);
    st();
    chk("port", {pout, poe}, 3);
    wr(`TW_CTRL_OFS, 32'hA0);
    st();
    chk("force", {pout, mat}, 0);
    wr(`TW_PORT_OFS, 2);
    wr(`TW_COMPARE_OFS, 3);
    wr(`TW_CTRL_OFS, 32'hB2);
    st();
    chk("force", {pout, pad}, 3);
    wr(`TW_CTRL_OFS, 32'h02);
    wr(`TW_COUNT_OFS, 0);
    wr(`TW_FLAGS_OFS, 3);
    tk(4);
    chk("off", pout, 0);
    wr(`TW_CTRL_OFS, 32'h12);
    st();
    chk("keep", pout, 1);
    chk("mat", mat, 1);
    rc("clr", `TW_COUNT_OFS, 0);
    tk(4);
    chk("tgl", pout, 0);
    tk(4);
    chk("tgl", pout, 1);
    wr(`TW_PORT_OFS, 0);
    st();
    chk("oe", poe, 0);
    // Compare below count: run through MAX before matching
    wr(`TW_COMPARE_OFS, 2);
    wr(`TW_COUNT_OFS, 32'hFD);
    wr(`TW_FLAGS_OFS, 3);
    tk(3);
    chk("wrap", {ovf, mat}, 2);
    tk(3);
    chk("wrap", mat, 1);
    // Fast PWM, both polarities; compare copied at the wrap
    wr(`TW_PORT_OFS, 2);
    for (int a = 2; a < 4; a++) begin
      wr(`TW_COMPARE_OFS, 32'h80);
      wr(`TW_CTRL_OFS, 32'(a * 16 + 3));
      wr(`TW_COUNT_OFS, 32'hFE);
      wr(`TW_FLAGS_OFS, 3);
      tk(1);
      chk("ovf", ovf, 0);
      tk(1);
      chk("ovf", ovf, 1);
      chk("bot", pout, 32'(a == 2));
      rc("cnt", `TW_COUNT_OFS, 0);
      wr(`TW_COUNT_OFS, 32'h7E);
      tk(2);
      chk("pre", pout, 32'(a == 2));
      tk(1);
      chk("cmp", pout, 32'(a != 2));
    end
    // Fast PWM toggle; a new compare waits for the wrap
    wr(`TW_CTRL_OFS, 32'h13);
    wr(`TW_COMPARE_OFS, 32'h20);
    wr(`TW_COUNT_OFS, 32'h7E);
    tk(3);
    chk("ftgl", pout, 0);
    wr(`TW_COUNT_OFS, 32'h1E);
    tk(3);
    chk("fbuf", pout, 0);
    // Compare at zero spikes, at MAX holds the bottom level
    wr(`TW_COMPARE_OFS, 0);
    wr(`TW_CTRL_OFS, 32'h23);
    wr(`TW_COUNT_OFS, 32'hFE);
    tk(2);
    chk("spk", pout, 1);
    tk(1);
    chk("spk", pout, 0);
    wr(`TW_COMPARE_OFS, 32'hFF);
    for (int p = 0; p < 2; p++) begin
      wr(`TW_COUNT_OFS, 32'hFE);
      tk(2);
    end
    chk("max", pout, 1);
    // Clear on match at zero with a steady tick toggles every clock
    wr(`TW_CTRL_OFS, 32'h12);
    wr(`TW_COMPARE_OFS, 0);
    @(posedge clk);
    tick <= 1;
    repeat (3) @(negedge clk);
    pv = pout;
    @(negedge clk);
    chk("half", pout ^ pv, 1);
    @(posedge clk);
    tick <= 0;
    st();
    // Hardware set wins over a service clear in the same cycle
    wr(`TW_CTRL_OFS, 0);
    wr(`TW_COUNT_OFS, 32'hFF);
    wr(`TW_FLAGS_OFS, 3);
    @(posedge clk);
    tick <= 1;
    ack <= 2'b01;
    @(posedge clk);
    tick <= 0;
    ack <= 0;
    st();
    chk("setwin", ovf, 1);
    @(posedge clk);
    ack <= 2'b01;
    @(posedge clk);
    ack <= 0;
    st();
    chk("svc", ovf, 0);
    // Reset in mid-run returns every register and output to zero
    @(posedge clk);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    chk("outs", {pout, poe, ovf, mat}, 0);
    for (int i = 0; i < 5; i++) rc("rst", 8'(4 * i), 0);
    end_sim();
  end

  initial begin
    #100000;
    error_cnt++;
    end_sim();
  end
endmodule // tw_timer8_tb
